// File: rtl/byte_arith_logic_decoder.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE_01 - 96/97: subtract indirect byte with borrow
// RULE_02 - 94: subtract immediate with borrow, two cycles
// RULE_03 - 04: increment accumulator, one cycle
// RULE_04 - 08-0F: increment selected bank register
// RULE_05 - 05: increment direct byte, two cycles
// RULE_06 - 06/07: increment indirect memory byte
// RULE_07 - 14: decrement accumulator, one cycle
// RULE_08 - 18-1F: decrement selected bank register
// RULE_09 - 15: decrement direct byte, two cycles
// RULE_10 - 16/17: decrement indirect memory byte
// RULE_11 - A3: increment data pointer, three cycles
// RULE_12 - A4: multiply accumulator by B, five cycles
// RULE_13 - 84: divide accumulator by B, five cycles
// RULE_14 - D4: decimal adjust accumulator, one cycle
// RULE_15 - 58-5F: AND bank register into accumulator
// RULE_16 - 56/57: AND indirect byte into accumulator
// RULE_17 - 35: AND direct byte, two bytes, two cycles
// RULE_18 - Wrap increments; carry left unchanged
// RULE_19 - Product/quotient to A, high/remainder to B
module byte_arith_logic_decoder (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        OP_VALID,
  input  wire logic [7:0]  OPCODE,
  input  wire logic [7:0]  OPERAND,
  input  wire logic [7:0]  ACC_IN,
  input  wire logic [7:0]  AUX_IN,
  input  wire logic [7:0]  PSW_IN,
  input  wire logic [15:0] DATA_POINTER_16_IN,
  input  wire logic [7:0]  SRC_DATA,
  output logic             OP_READY,
  output logic             OP_ILLEGAL,
  output logic             SRC_REQ,
  output logic [2:0]       SRC_KIND,
  output logic [7:0]       SRC_ADDR,
  output logic             DONE,
  output logic             ACC_WE,
  output logic [7:0]       ACC_OUT,
  output logic             AUX_WE,
  output logic [7:0]       AUX_OUT,
  output logic             PSW_WE,
  output logic [7:0]       PSW_OUT,
  output logic             DATA_POINTER_16_WE,
  output logic [15:0]      DATA_POINTER_16_OUT,
  output logic             MEM_WE,
  output logic [2:0]       MEM_KIND,
  output logic [7:0]       MEM_ADDR,
  output logic [7:0]       MEM_DATA
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } state_e;

  decode_bus_if dbus ();

  opcode_decoder u_dec (
    .opcode (OPCODE),
    .dbus   (dbus)
  );

  state_e                     state_q;
  logic [2:0]                 cnt_q;
  arith_decode_pkg::op_kind_e kind_q;
  arith_decode_pkg::op_src_e  src_q;
  logic [2:0]                 sel_q;
  logic [7:0]                 opnd_q;
  logic [7:0]                 acc_q;
  logic [7:0]                 aux_q;
  logic [7:0]                 psw_q;
  logic [15:0]                data_pointer_16_q;

  logic                       take;
  logic [7:0]                 src_val;
  logic [8:0]                 sub_full;
  logic [4:0]                 sub_low;
  logic [15:0]                prod;
  logic [7:0]                 r_acc;
  logic [7:0]                 r_aux;
  logic [7:0]                 r_psw;
  logic [7:0]                 r_mem;
  logic                       w_acc;
  logic                       w_aux;
  logic                       w_psw;
  logic                       w_mem;
  logic                       w_dp;

  // Decimal adjust after packed BCD addition
  function automatic logic [8:0] dec_adj(input logic [7:0] a, input logic cy, input logic ac);
    logic [8:0] t;
    t = {1'b0, a};
    if (t[3:0] > 4'h9 || ac) begin
      t = t + 9'h006;
    end
    if (t[8:4] > 5'h09 || cy) begin
      t = t + 9'h060;
    end
    dec_adj = {t[8] | cy, t[7:0]};
  endfunction : dec_adj

  // New opcode is taken only when idle
  assign OP_READY   = (state_q == ST_IDLE);
  assign take       = OP_READY && OP_VALID && dbus.legal;
  assign OP_ILLEGAL = OP_READY && OP_VALID && !dbus.legal;

  // Latch operands at issue so the datapath may change them meanwhile
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      kind_q <= arith_decode_pkg::K_NONE;
      src_q  <= arith_decode_pkg::S_ACC;
      sel_q  <= 3'h0;
      opnd_q <= 8'h00;
      acc_q  <= 8'h00;
      aux_q  <= 8'h00;
      psw_q  <= 8'h00;
      data_pointer_16_q <= 16'h0000;
    end else if (take) begin
      kind_q <= dbus.kind;
      src_q  <= dbus.src;
      sel_q  <= dbus.sel;
      opnd_q <= OPERAND;
      acc_q  <= ACC_IN;
      aux_q  <= AUX_IN;
      psw_q  <= PSW_IN;
      data_pointer_16_q <= DATA_POINTER_16_IN;
    end
  end

  // Cycle count sequencing; the ST_DONE cycle yields results
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (take) begin
            cnt_q   <= dbus.cycles - 3'h1;
            state_q <= (dbus.cycles == arith_decode_pkg::CYC_ONE) ? ST_DONE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            state_q <= ST_DONE; // RULE_11 RULE_12 RULE_13
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Source operand fetch request, held through the instruction
  assign SRC_REQ  = (state_q != ST_IDLE) && (src_q != arith_decode_pkg::S_ACC)
                    && (src_q != arith_decode_pkg::S_IMM);
  assign SRC_KIND = src_q;
  // Indirect forms name pointer 0 or 1 only, so the index is the opcode's low bit
  assign SRC_ADDR = (src_q == arith_decode_pkg::S_DIR) ? opnd_q
                  : (src_q == arith_decode_pkg::S_IND) ? {7'h00, sel_q[0]} // RULE_06
                  : {5'h00, sel_q};

  // Pick operand: immediate comes from the second byte, others from datapath
  always_comb begin
    unique case (src_q)
      arith_decode_pkg::S_ACC: src_val = acc_q;
      arith_decode_pkg::S_IMM: src_val = opnd_q; // RULE_02
      default:                 src_val = SRC_DATA;
    endcase
  end

  assign sub_full = {1'b0, acc_q} - {1'b0, src_val} - {8'h00, psw_q[arith_decode_pkg::CY_POS]};
  assign sub_low  = {1'b0, acc_q[3:0]} - {1'b0, src_val[3:0]}
                    - {4'h0, psw_q[arith_decode_pkg::CY_POS]};
  assign prod     = acc_q * aux_q;

  // Result computation; inc/dec wrap and never touch carry
  always_comb begin
    logic [8:0] da;
    da    = dec_adj(acc_q, psw_q[arith_decode_pkg::CY_POS], psw_q[arith_decode_pkg::AC_POS]);
    r_acc = acc_q;
    r_aux = aux_q;
    r_psw = psw_q;
    r_mem = src_val;
    w_acc = 1'b0;
    w_aux = 1'b0;
    w_psw = 1'b0;
    w_mem = 1'b0;
    w_dp  = 1'b0;
    unique case (kind_q)
      arith_decode_pkg::K_SUBTRACT_WITH_BORROW: begin
        r_acc = sub_full[7:0]; // RULE_01
        r_psw[arith_decode_pkg::CY_POS] = sub_full[8];
        r_psw[arith_decode_pkg::AC_POS] = sub_low[4];
        r_psw[arith_decode_pkg::OV_POS] = (acc_q[7] ^ src_val[7]) & (acc_q[7] ^ sub_full[7]);
        w_acc = 1'b1;
        w_psw = 1'b1;
      end
      arith_decode_pkg::K_INC, arith_decode_pkg::K_DEC: begin
        // 8-bit wrap; flags are left alone
        r_mem = (kind_q == arith_decode_pkg::K_INC) ? src_val + 8'h01
                                                     : src_val - 8'h01; // RULE_18
        if (src_q == arith_decode_pkg::S_ACC) begin
          r_acc = r_mem; // RULE_03 RULE_07
          w_acc = 1'b1;
        end else begin
          w_mem = 1'b1; // RULE_04 RULE_05 RULE_06 RULE_08 RULE_09 RULE_10
        end
      end
      arith_decode_pkg::K_AND: begin
        r_acc = acc_q & src_val; // RULE_15 RULE_16 RULE_17
        w_acc = 1'b1;
      end
      arith_decode_pkg::K_INCDP: begin
        w_dp = 1'b1; // RULE_11
      end
      arith_decode_pkg::K_MUL: begin
        r_acc = prod[7:0]; // RULE_12 RULE_19
        r_aux = prod[15:8];
        r_psw[arith_decode_pkg::CY_POS] = 1'b0;
        r_psw[arith_decode_pkg::OV_POS] = (prod[15:8] != 8'h00);
        w_acc = 1'b1;
        w_aux = 1'b1;
        w_psw = 1'b1;
      end
      arith_decode_pkg::K_DIV: begin
        // Divide by zero leaves A and B undefined in spirit; we keep them and flag overflow
        r_psw[arith_decode_pkg::CY_POS] = 1'b0;
        r_psw[arith_decode_pkg::OV_POS] = (aux_q == 8'h00);
        if (aux_q != 8'h00) begin
          r_acc = acc_q / aux_q; // RULE_13 RULE_19
          r_aux = acc_q % aux_q;
          w_acc = 1'b1;
          w_aux = 1'b1;
        end
        w_psw = 1'b1;
      end
      arith_decode_pkg::K_DADJ: begin
        r_acc = da[7:0]; // RULE_14
        r_psw[arith_decode_pkg::CY_POS] = da[8];
        w_acc = 1'b1;
        w_psw = 1'b1;
      end
      default: begin
        r_acc = acc_q;
      end
    endcase
  end

  // Registered results, write strobes are one-cycle pulses
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      DONE     <= 1'b0;
      ACC_WE   <= 1'b0;
      AUX_WE   <= 1'b0;
      PSW_WE   <= 1'b0;
      DATA_POINTER_16_WE  <= 1'b0;
      MEM_WE   <= 1'b0;
      ACC_OUT  <= 8'h00;
      AUX_OUT  <= 8'h00;
      PSW_OUT  <= 8'h00;
      DATA_POINTER_16_OUT <= 16'h0000;
      MEM_KIND <= 3'h0;
      MEM_ADDR <= 8'h00;
      MEM_DATA <= 8'h00;
    end else begin
      DONE    <= (state_q == ST_DONE);
      ACC_WE  <= (state_q == ST_DONE) && w_acc;
      AUX_WE  <= (state_q == ST_DONE) && w_aux;
      PSW_WE  <= (state_q == ST_DONE) && w_psw;
      DATA_POINTER_16_WE <= (state_q == ST_DONE) && w_dp;
      MEM_WE  <= (state_q == ST_DONE) && w_mem;
      if (state_q == ST_DONE) begin
        ACC_OUT  <= r_acc;
        AUX_OUT  <= r_aux;
        PSW_OUT  <= r_psw;
        DATA_POINTER_16_OUT <= data_pointer_16_q + 16'h0001; // RULE_18
        MEM_KIND <= src_q;
        MEM_ADDR <= SRC_ADDR;
        MEM_DATA <= r_mem;
      end
    end
  end

endmodule : byte_arith_logic_decoder
`default_nettype wire

// File: rtl/arith_decode_pkg.sv
package arith_decode_pkg;

  // Opcode bases and fixed opcodes of this instruction group
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_IND   = 8'h96;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_IMM   = 8'h94;
  localparam logic [7:0] OP_INC_ACC    = 8'h04;
  localparam logic [7:0] OP_INC_BANK   = 8'h08;
  localparam logic [7:0] OP_INC_DIR    = 8'h05;
  localparam logic [7:0] OP_INC_IND    = 8'h06;
  localparam logic [7:0] OP_DEC_ACC    = 8'h14;
  localparam logic [7:0] OP_DEC_BANK   = 8'h18;
  localparam logic [7:0] OP_DEC_DIR    = 8'h15;
  localparam logic [7:0] OP_DEC_IND    = 8'h16;
  localparam logic [7:0] OP_INC_DATA_POINTER_16   = 8'ha3;
  localparam logic [7:0] OP_MUL        = 8'ha4;
  localparam logic [7:0] OP_DIV        = 8'h84;
  localparam logic [7:0] OP_DADJ       = 8'hd4;
  localparam logic [7:0] OP_AND_BANK   = 8'h58;
  localparam logic [7:0] OP_AND_IND    = 8'h56;
  localparam logic [7:0] OP_AND_DIR    = 8'h35;

  // Masks for opcode families
  localparam logic [7:0] MASK_BANK     = 8'hf8;
  localparam logic [7:0] MASK_IND      = 8'hfe;

  // Machine cycle counts per instruction class
  localparam logic [2:0] CYC_ONE       = 3'h1;
  localparam logic [2:0] CYC_TWO       = 3'h2;
  localparam logic [2:0] CYC_DATA_POINTER_16      = 3'h3;
  localparam logic [2:0] CYC_MULDIV    = 3'h5;

  // Bit positions of carry, auxiliary carry and overflow in the flag vector given to the block
  localparam int         CY_POS        = 7;
  localparam int         AC_POS        = 6;
  localparam int         OV_POS        = 2;

  // Operation classes
  typedef enum logic [3:0] {
    K_NONE, K_SUBTRACT_WITH_BORROW, K_INC, K_DEC, K_AND, K_INCDP, K_MUL, K_DIV, K_DADJ
  } op_kind_e;

  // Operand source
  typedef enum logic [2:0] {
    S_ACC, S_BANK, S_DIR, S_IND, S_IMM
  } op_src_e;

endpackage : arith_decode_pkg

// File: rtl/decode_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
// Decoded operation passed from the decoder to the executing datapath
interface decode_bus_if;
  arith_decode_pkg::op_kind_e kind;
  arith_decode_pkg::op_src_e  src;
  logic [2:0]                 sel;
  logic [2:0]                 cycles;
  logic                       two_byte;
  logic                       legal;
  modport dec (output kind, output src, output sel, output cycles, output two_byte,
               output legal);
  modport exe (input kind, input src, input sel, input cycles, input two_byte,
               input legal);
endinterface : decode_bus_if
`default_nettype wire

// File: rtl/opcode_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module opcode_decoder (
  input  wire logic [7:0] opcode,
  decode_bus_if.dec       dbus
);

  // Compare an opcode against a family base under a mask
  function automatic logic fam(input logic [7:0] op, input logic [7:0] base,
                               input logic [7:0] mask);
    fam = ((op & mask) == base);
  endfunction : fam

  // Pure table lookup; one-byte ops default here
  always_comb begin
    dbus.kind     = arith_decode_pkg::K_NONE;
    dbus.src      = arith_decode_pkg::S_ACC;
    dbus.sel      = opcode[2:0];
    dbus.cycles   = arith_decode_pkg::CYC_ONE;
    dbus.two_byte = 1'b0;
    dbus.legal    = 1'b1;
    if (fam(opcode, arith_decode_pkg::OP_SUBTRACT_WITH_BORROW_IND, arith_decode_pkg::MASK_IND)) begin
      dbus.kind = arith_decode_pkg::K_SUBTRACT_WITH_BORROW; // RULE_01
      dbus.src  = arith_decode_pkg::S_IND;
    end else if (opcode == arith_decode_pkg::OP_SUBTRACT_WITH_BORROW_IMM) begin
      dbus.kind     = arith_decode_pkg::K_SUBTRACT_WITH_BORROW; // RULE_02
      dbus.src      = arith_decode_pkg::S_IMM;
      dbus.cycles   = arith_decode_pkg::CYC_TWO;
      dbus.two_byte = 1'b1;
    end else if (opcode == arith_decode_pkg::OP_INC_ACC) begin
      dbus.kind = arith_decode_pkg::K_INC; // RULE_03
    end else if (fam(opcode, arith_decode_pkg::OP_INC_BANK, arith_decode_pkg::MASK_BANK)) begin
      dbus.kind = arith_decode_pkg::K_INC; // RULE_04
      dbus.src  = arith_decode_pkg::S_BANK;
    end else if (opcode == arith_decode_pkg::OP_INC_DIR) begin
      dbus.kind     = arith_decode_pkg::K_INC; // RULE_05
      dbus.src      = arith_decode_pkg::S_DIR;
      dbus.cycles   = arith_decode_pkg::CYC_TWO;
      dbus.two_byte = 1'b1;
    end else if (fam(opcode, arith_decode_pkg::OP_INC_IND, arith_decode_pkg::MASK_IND)) begin
      dbus.kind = arith_decode_pkg::K_INC; // RULE_06
      dbus.src  = arith_decode_pkg::S_IND;
    end else if (opcode == arith_decode_pkg::OP_DEC_ACC) begin
      dbus.kind = arith_decode_pkg::K_DEC; // RULE_07
    end else if (fam(opcode, arith_decode_pkg::OP_DEC_BANK, arith_decode_pkg::MASK_BANK)) begin
      dbus.kind = arith_decode_pkg::K_DEC; // RULE_08
      dbus.src  = arith_decode_pkg::S_BANK;
    end else if (opcode == arith_decode_pkg::OP_DEC_DIR) begin
      dbus.kind     = arith_decode_pkg::K_DEC; // RULE_09
      dbus.src      = arith_decode_pkg::S_DIR;
      dbus.cycles   = arith_decode_pkg::CYC_TWO;
      dbus.two_byte = 1'b1;
    end else if (fam(opcode, arith_decode_pkg::OP_DEC_IND, arith_decode_pkg::MASK_IND)) begin
      dbus.kind = arith_decode_pkg::K_DEC; // RULE_10
      dbus.src  = arith_decode_pkg::S_IND;
    end else if (opcode == arith_decode_pkg::OP_INC_DATA_POINTER_16) begin
      dbus.kind   = arith_decode_pkg::K_INCDP; // RULE_11
      dbus.cycles = arith_decode_pkg::CYC_DATA_POINTER_16;
    end else if (opcode == arith_decode_pkg::OP_MUL) begin
      dbus.kind   = arith_decode_pkg::K_MUL; // RULE_12
      dbus.cycles = arith_decode_pkg::CYC_MULDIV;
    end else if (opcode == arith_decode_pkg::OP_DIV) begin
      dbus.kind   = arith_decode_pkg::K_DIV; // RULE_13
      dbus.cycles = arith_decode_pkg::CYC_MULDIV;
    end else if (opcode == arith_decode_pkg::OP_DADJ) begin
      dbus.kind = arith_decode_pkg::K_DADJ; // RULE_14
    end else if (fam(opcode, arith_decode_pkg::OP_AND_BANK, arith_decode_pkg::MASK_BANK)) begin
      dbus.kind = arith_decode_pkg::K_AND; // RULE_15
      dbus.src  = arith_decode_pkg::S_BANK;
    end else if (fam(opcode, arith_decode_pkg::OP_AND_IND, arith_decode_pkg::MASK_IND)) begin
      dbus.kind = arith_decode_pkg::K_AND; // RULE_16
      dbus.src  = arith_decode_pkg::S_IND;
    end else if (opcode == arith_decode_pkg::OP_AND_DIR) begin
      dbus.kind     = arith_decode_pkg::K_AND; // RULE_17
      dbus.src      = arith_decode_pkg::S_DIR;
      dbus.cycles   = arith_decode_pkg::CYC_TWO;
      dbus.two_byte = 1'b1;
    end else begin
      dbus.legal = 1'b0;
    end
  end

endmodule : opcode_decoder
`default_nettype wire

// File: tb/byte_arith_logic_decoder_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// Timing and result checks seen only at the decoder's top-level ports
module arith_port_checker (
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  input wire logic        OP_VALID,
  input wire logic [7:0]  OPCODE,
  input wire logic [7:0]  ACC_IN,
  input wire logic [7:0]  AUX_IN,
  input wire logic [15:0] DATA_POINTER_16_IN,
  input wire logic        OP_READY,
  input wire logic        OP_ILLEGAL,
  input wire logic        DONE,
  input wire logic        ACC_WE,
  input wire logic [7:0]  ACC_OUT,
  input wire logic        AUX_WE,
  input wire logic [7:0]  AUX_OUT,
  input wire logic        DATA_POINTER_16_WE,
  input wire logic [15:0] DATA_POINTER_16_OUT,
  input wire logic        MEM_WE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic legal, take, two, dpi, mdv;
  // Opcode classes by length of execution; one-cycle is whatever is left
  assign legal = OPCODE inside {[8'h04:8'h0f], [8'h14:8'h1f], 8'h35, [8'h56:8'h5f], 8'h84,
                                8'h94, 8'h96, 8'h97, 8'ha3, 8'ha4, 8'hd4};
  assign take = OP_READY && OP_VALID && legal;
  assign two = OPCODE inside {8'h05, 8'h15, 8'h35, 8'h94};
  assign dpi = OPCODE == 8'ha3;
  assign mdv = OPCODE inside {8'h84, 8'ha4};
  sequence wait2; !DONE [*2] ##1 DONE; endsequence
  sequence wait3; !DONE [*3] ##1 DONE; endsequence
  sequence wait5; !DONE [*5] ##1 DONE; endsequence
  property data_pointer_16_inc_p;
    logic [15:0] d;
    (take && dpi, d = DATA_POINTER_16_IN + 16'h1) |-> ##4 DATA_POINTER_16_WE && DATA_POINTER_16_OUT == d;
  endproperty
  property acc_inc_p;
    logic [7:0] a;
    (take && OPCODE == 8'h04, a = ACC_IN + 8'h1) |-> ##2 ACC_WE && ACC_OUT == a;
  endproperty
  property mul_split_p;
    logic [15:0] p;
    (take && OPCODE == 8'ha4, p = ACC_IN * AUX_IN) |-> ##6 ACC_WE && AUX_WE && {AUX_OUT, ACC_OUT} == p;
  endproperty
  one_cycle_a: assert property (take && !two && !dpi && !mdv |=> !DONE ##1 DONE)
    else $error("one-cycle opcode finished at the wrong time");
  two_cycle_a: assert property (take && two |=> wait2)
    else $error("two-cycle opcode finished at the wrong time");
  data_pointer_16_timing_a: assert property (take && dpi |=> wait3)
    else $error("pointer increment finished at the wrong time");
  muldiv_timing_a: assert property (take && mdv |=> wait5)
    else $error("multiply or divide finished at the wrong time");
  data_pointer_16_wrap_a: assert property (data_pointer_16_inc_p)
    else $error("pointer increment gave the wrong value");
  acc_inc_a: assert property (acc_inc_p)
    else $error("accumulator increment gave the wrong value");
  mul_split_a: assert property (mul_split_p)
    else $error("product bytes placed wrongly");
  busy_refuse_a: assert property (take |=> !OP_READY)
    else $error("ready stayed high after an opcode was taken");
  illegal_flag_a: assert property (OP_READY && OP_VALID |-> OP_ILLEGAL == !legal)
    else $error("illegal flag disagrees with the opcode group");
  strobe_done_a: assert property (ACC_WE || AUX_WE || DATA_POINTER_16_WE || MEM_WE |-> DONE)
    else $error("write strobe outside the completion cycle");
endmodule : arith_port_checker
`default_nettype wire

// File: tb/core_side_model.sv
`timescale 1ns/100ps
`default_nettype none
// Bank registers and data memory as the datapath would hold them
module core_side_model (
  input  wire logic       clk,
  input  wire logic       src_req,
  input  wire logic [2:0] src_kind,
  input  wire logic [7:0] src_addr,
  input  wire logic       mem_we,
  input  wire logic [2:0] mem_kind,
  input  wire logic [7:0] mem_addr,
  input  wire logic [7:0] mem_data,
  output logic      [7:0] src_data
);
  logic [7:0] bank [8];
  logic [7:0] dmem [256];
  logic [7:0] last_q;
  // Distinct contents per address so a wrong index shows up
  initial begin
    for (int i = 0; i < 256; i++) dmem[i] = 8'(i * 7 + 3);
    for (int i = 0; i < 8; i++) bank[i] = 8'(i * 29 + 8'h41);
  end
  // Outside a request the line toggles so a stale sample never looks right
  always_comb begin
    case (src_req ? src_kind : 3'h0)
      3'h1: src_data = bank[src_addr[2:0]];
      3'h2: src_data = dmem[src_addr];
      3'h3: src_data = dmem[bank[src_addr[0]]];
      default: src_data = ~last_q;
    endcase
  end
  always_ff @(posedge clk) last_q <= src_data;
  // Write-back lands mid-cycle, before the next opcode can read it
  always @(negedge clk) begin
    if (mem_we === 1'b1 && mem_kind == 3'h1) bank[mem_addr[2:0]] = mem_data;
    if (mem_we === 1'b1 && mem_kind == 3'h2) dmem[mem_addr] = mem_data;
    if (mem_we === 1'b1 && mem_kind == 3'h3) dmem[bank[mem_addr[0]]] = mem_data;
  end
endmodule : core_side_model
`default_nettype wire

// File: tb/byte_arith_logic_decoder_bench.sv
`timescale 1ns/100ps
`default_nettype none
module byte_arith_logic_decoder_bench;
  typedef struct packed {
    logic [7:0] we; logic [7:0] acc; logic [7:0] aux; logic [7:0] mem;
    logic [7:0] madr; logic cy; logic [15:0] dp; logic [2:0] mk;
  } note_s;
  logic SYS_CLK = 0, RESET = 1, OP_VALID = 0;
  logic [7:0] OPCODE = 0, OPERAND = 0, ACC_IN = 0, AUX_IN = 0, PSW_IN = 0;
  logic [15:0] DATA_POINTER_16_IN = 0;
  logic [7:0] SRC_DATA, SRC_ADDR, ACC_OUT, AUX_OUT, PSW_OUT, MEM_ADDR, MEM_DATA;
  logic [2:0] SRC_KIND, MEM_KIND;
  logic [15:0] DATA_POINTER_16_OUT;
  logic OP_READY, OP_ILLEGAL, SRC_REQ, DONE, ACC_WE, AUX_WE, PSW_WE, DATA_POINTER_16_WE, MEM_WE;
  note_s notes[$];
  note_s e;
  int n_mismatch = 0, checked = 0, cycles = 0;
  byte_arith_logic_decoder dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .OP_VALID(OP_VALID),
    .OPCODE(OPCODE), .OPERAND(OPERAND), .ACC_IN(ACC_IN), .AUX_IN(AUX_IN), .PSW_IN(PSW_IN),
    .DATA_POINTER_16_IN(DATA_POINTER_16_IN), .SRC_DATA(SRC_DATA), .OP_READY(OP_READY), .OP_ILLEGAL(OP_ILLEGAL),
    .SRC_REQ(SRC_REQ), .SRC_KIND(SRC_KIND), .SRC_ADDR(SRC_ADDR), .DONE(DONE), .ACC_WE(ACC_WE),
    .ACC_OUT(ACC_OUT), .AUX_WE(AUX_WE), .AUX_OUT(AUX_OUT), .PSW_WE(PSW_WE), .PSW_OUT(PSW_OUT),
    .DATA_POINTER_16_WE(DATA_POINTER_16_WE), .DATA_POINTER_16_OUT(DATA_POINTER_16_OUT), .MEM_WE(MEM_WE), .MEM_KIND(MEM_KIND),
    .MEM_ADDR(MEM_ADDR), .MEM_DATA(MEM_DATA));
  core_side_model m (.clk(SYS_CLK), .src_req(SRC_REQ), .src_kind(SRC_KIND), .src_addr(SRC_ADDR),
    .mem_we(MEM_WE), .mem_kind(MEM_KIND), .mem_addr(MEM_ADDR), .mem_data(MEM_DATA),
    .src_data(SRC_DATA));
  // Clock and a hang limit well above the expected run of about 1300 cycles
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  function automatic logic legal(input logic [7:0] o);
    return o inside {[8'h04:8'h0f], [8'h14:8'h1f], 8'h35, [8'h56:8'h5f], 8'h84, 8'h94, 8'h96,
                     8'h97, 8'ha3, 8'ha4, 8'hd4};
  endfunction : legal
  function automatic logic [7:0] pick(input int p);
    return (p == 0) ? 8'hff : (p == 1) ? 8'h00 : 8'($urandom);
  endfunction : pick
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  // Expected outcome of one taken opcode from the inputs held at the take edge
  function automatic note_s predict(input logic [7:0] op);
    note_s n;
    logic [7:0] s;
    logic [8:0] t;
    logic [15:0] p;
    logic c;
    n = '0;
    n.cy = PSW_IN[7];
    n.madr = 8'(op[0]);
    n.mk = 3'h3;
    s = m.dmem[m.bank[op[0]]];
    if (op inside {[8'h08:8'h0f], [8'h18:8'h1f], [8'h58:8'h5f]}) begin
      s = m.bank[op[2:0]];
      n.madr = 8'(op[2:0]);
      n.mk = 3'h1;
    end
    if (op inside {8'h05, 8'h15, 8'h35}) begin
      s = m.dmem[OPERAND];
      n.madr = OPERAND;
      n.mk = 3'h2;
    end
    if (op == 8'h94) s = OPERAND;
    if (op inside {8'h04, 8'h14}) begin
      n.we = 8'h8;
      n.acc = op[4] ? ACC_IN - 8'h1 : ACC_IN + 8'h1;
    end else if (op < 8'h20) begin
      n.we = 8'h1;
      n.mem = op[4] ? s - 8'h1 : s + 8'h1;
    end else if (op inside {8'h94, 8'h96, 8'h97}) begin
      t = {1'b0, ACC_IN} - {1'b0, s} - {8'h0, PSW_IN[7]};
      n.we = 8'h8;
      {n.cy, n.acc} = t;
    end else if (op == 8'ha3) begin
      n.we = 8'h2;
      n.dp = DATA_POINTER_16_IN + 16'h1;
    end else if (op == 8'ha4) begin
      p = ACC_IN * AUX_IN;
      n.we = 8'hc;
      {n.aux, n.acc} = p;
      n.cy = 1'b0;
    end else if (op == 8'h84) begin
      n.cy = 1'b0;
      if (AUX_IN != 8'h0) begin
        n.we = 8'hc;
        n.acc = ACC_IN / AUX_IN;
        n.aux = ACC_IN % AUX_IN;
      end
    end else if (op == 8'hd4) begin
      t = {1'b0, ACC_IN};
      if (t[3:0] > 4'h9 || PSW_IN[6]) t = t + 9'h6;
      c = t[8] | PSW_IN[7];
      if (t[7:4] > 4'h9 || c) t = t + 9'h60;
      n.we = 8'h8;
      n.acc = t[7:0];
      n.cy = c | t[8];
    end else begin
      n.we = 8'h8;
      n.acc = ACC_IN & s;
    end
    return n;
  endfunction : predict
  // Drive one opcode; entered and left at a rising edge so issues run back to back
  task automatic issue(input logic [7:0] op, input int p);
    OP_VALID <= 1'b1;
    OPCODE <= op;
    OPERAND <= pick(p);
    ACC_IN <= pick(p);
    AUX_IN <= pick(p);
    PSW_IN <= pick(p);
    DATA_POINTER_16_IN <= {pick(p), pick(p)};
    @(negedge SYS_CLK);
    while (OP_READY !== 1'b1) @(negedge SYS_CLK);
    cmp_byte({7'h0, OP_ILLEGAL}, {7'h0, !legal(op)});
    @(posedge SYS_CLK);
    if (legal(op)) notes.push_back(predict(op));
  endtask : issue
  // Results are matched against the oldest note whenever a completion appears
  always @(negedge SYS_CLK) begin
    if (DONE === 1'b1 && notes.size() == 0) cmp_byte(8'h1, 8'h0);
    if (DONE === 1'b1 && notes.size() != 0) begin
      e = notes.pop_front();
      cmp_byte({4'h0, ACC_WE, AUX_WE, DATA_POINTER_16_WE, MEM_WE}, e.we);
      if (e.we[3]) cmp_byte(ACC_OUT, e.acc);
      if (e.we[2]) cmp_byte(AUX_OUT, e.aux);
      if (e.we[1]) cmp_word(DATA_POINTER_16_OUT, e.dp);
      if (e.we[0]) cmp_byte(MEM_DATA, e.mem);
      if (e.we[0]) cmp_byte(MEM_ADDR, e.madr);
      if (e.we[0]) cmp_byte({5'h0, MEM_KIND}, {5'h0, e.mk});
      if (PSW_WE === 1'b1) cmp_byte({7'h0, PSW_OUT[7]}, {7'h0, e.cy});
    end
  end
  task automatic test_done;
    if (notes.size() != 0) n_mismatch++;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  // Every opcode in four passes: all ones, all zeros, then random operands
  initial begin
    void'($urandom(32'h4e2f4e39));
    repeat (12) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(negedge SYS_CLK);
    cmp_byte({7'h0, OP_READY}, 8'h1);
    cmp_byte({7'h0, DONE}, 8'h0);
    @(posedge SYS_CLK);
    for (int p = 0; p < 4; p++) begin
      for (int op = 0; op < 256; op++) issue(8'(op), p);
      $display("pass %0d done", p);
    end
    OP_VALID <= 1'b0;
    repeat (10) @(posedge SYS_CLK);
    test_done();
  end
endmodule : byte_arith_logic_decoder_bench
bind byte_arith_logic_decoder arith_port_checker chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .OP_VALID(OP_VALID), .OPCODE(OPCODE), .ACC_IN(ACC_IN), .AUX_IN(AUX_IN), .DATA_POINTER_16_IN(DATA_POINTER_16_IN),
  .OP_READY(OP_READY), .OP_ILLEGAL(OP_ILLEGAL), .DONE(DONE), .ACC_WE(ACC_WE), .ACC_OUT(ACC_OUT),
  .AUX_WE(AUX_WE), .AUX_OUT(AUX_OUT), .DATA_POINTER_16_WE(DATA_POINTER_16_WE), .DATA_POINTER_16_OUT(DATA_POINTER_16_OUT), .MEM_WE(MEM_WE));
`default_nettype wire
